/* File: scan_pkg.sv */
package scan_pkg;
    localparam int IR_WIDTH       = 3;
    localparam int ID_WIDTH       = 32;
    localparam int BSR_LEN_SMALL  = 85;
    localparam int BSR_LEN_FINE   = 89;
    localparam int RESET_TMS_EDGES = 5;
    localparam int CLK_PERIOD_NS   = 25;
    localparam int TCK_HALF_NS     = 100;
    localparam int TCK_HALF_CYCLES = TCK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [1:0] IR_CAPTURE_PATTERN = 2'h1;
    localparam logic       OE_CELL_RESET      = 1'b1;
    // id value arbitrary, bit 0 marks presence
    localparam logic [31:0] ID_WORD_DEFAULT = 32'h1234_5ABD;

    typedef enum logic [2:0] {
        INS_EXT_TEST   = 3'h0,
        INS_IDENT      = 3'h1,
        INS_SAMPLE_HIZ = 3'h2,
        INS_SAMPLE_PRE = 3'h4,
        INS_BYPASS     = 3'h7
    } instr_type;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_type;

    function automatic tap_state_type tap_next(tap_state_type s, logic tms);
        tap_state_type n;
        n = ST_RESET;
        unique case (s)
            ST_RESET:    n = tms ? ST_RESET : ST_IDLE;
            ST_IDLE:     n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR:   n = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR:   n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR:   n = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR:   n = tms ? ST_SEL_DR : ST_IDLE;
        endcase
        return n;
    endfunction
endpackage

/* File: scan_if.sv */
`timescale 1ns/1ps
interface scan_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_o;
    logic tdo_oe_n;

    modport device (
        input  tck,
        input  tms,
        input  tdi,
        output tdo_o,
        output tdo_oe_n
    );
    modport controller (
        output tck,
        output tms,
        output tdi,
        input  tdo_o,
        input  tdo_oe_n
    );
endinterface

/* File: scan_device.sv */
`timescale 1ns/1ps
// How it works
// [R1] three-bit instruction register, eight codes
// [R2] instruction shifted in, applied at Update-IR
// [R3] external test drives preload, selects boundary chain
// [R4] identification word shifted out in Shift-DR
// [R5] reset and Test-Logic-Reset load identification
// [R6] sample high-z tristates outputs, selects boundary
// [R7] sample/preload captures pins at Capture-DR
// [R8] captured boundary data shifted out afterwards
// [R9] shifted pattern latched onto parallel outputs
// [R10] capture shifts out while preload shifts in
// [R11] bypass puts one-bit register in chain
// [R12] output-enable cell at last chain position
// [R13] external test: enable cell gates output bus
// [R14] enable cell shifted, latched at Update-DR
// [R15] enable cell latch preset high at reset
// [R16] controller loads reserved codes too, applied at Update-IR
// [R17] reserved codes behave as bypass
// [R18] codes 000,001,010,100,111; rest reserved
// [R19] five tms-high edges reset the controller
// [R20] Capture-IR loads 01 into low bits
// [R21] sample on rising, tdo on falling; msb in
module scan_device
    import scan_pkg::*;
#(
    parameter int          BSR_LEN = BSR_LEN_SMALL,
    parameter logic [31:0] ID_WORD = ID_WORD_DEFAULT
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    scan_if.device                  port,
    input  wire logic [BSR_LEN-2:0] pin_sample,
    output logic      [BSR_LEN-2:0] pin_drive,
    output logic                    pin_drive_en,
    output logic                    mem_out_en,
    output logic [scan_pkg::IR_WIDTH-1:0] instr_active
);
    import scan_pkg::*;

    logic [2:0] tck_s_q, tms_s_q, tdi_s_q;
    logic       rise, fall;
    tap_state_type      state_q;
    logic [IR_WIDTH-1:0] ir_q, ir_shift_q;
    logic [ID_WIDTH-1:0] id_q;
    logic [BSR_LEN-1:0]  bsr_q, preload_q;
    logic                byp_q, tdo_q, tdo_oe_n_q;
    logic                sel_bsr, sel_id, sel_chain;
    logic                tdo_d;
    logic [BSR_LEN-2:0]  pin_s1_q, pin_s2_q;

    // pins belong to the memory's domain: two flops before capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_sample;
            pin_s2_q <= pin_s1_q;
        end
    end

    // two-stage sync, third stage for edge detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_s_q <= 3'h0;
            tms_s_q <= 3'h7;
            tdi_s_q <= 3'h7;
        end else begin
            tck_s_q <= {tck_s_q[1:0], port.tck};
            tms_s_q <= {tms_s_q[1:0], port.tms};
            tdi_s_q <= {tdi_s_q[1:0], port.tdi};
        end
    end
    assign rise = tck_s_q[1] & ~tck_s_q[2]; // R21
    assign fall = ~tck_s_q[1] & tck_s_q[2]; // R21

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RESET;
        end else if (rise) begin
            state_q <= tap_next(state_q, tms_s_q[1]); // R19
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift_q <= IR_WIDTH'(INS_IDENT);
            ir_q       <= IR_WIDTH'(INS_IDENT); // R5
        end else if (rise) begin
            unique case (state_q)
                ST_RESET:    ir_q <= IR_WIDTH'(INS_IDENT); // R5
                ST_CAP_IR:   ir_shift_q <= {1'b0, IR_CAPTURE_PATTERN}; // R20
                ST_SHIFT_IR: ir_shift_q <= {tdi_s_q[1],
                                            ir_shift_q[IR_WIDTH-1:1]}; // R2
                ST_UPD_IR:   ir_q <= ir_shift_q; // R1 R2
                default: ;
            endcase
        end
    end

    assign sel_bsr = (ir_q == INS_EXT_TEST) || (ir_q == INS_SAMPLE_HIZ)
                  || (ir_q == INS_SAMPLE_PRE); // R3 R6 R8 R18
    assign sel_id  = (ir_q == INS_IDENT); // R4
    // anything else, reserved codes included, is bypass
    assign sel_chain = sel_bsr | sel_id; // R11 R17

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_q  <= '0;
            byp_q <= 1'b0;
            bsr_q <= '0;
        end else if (rise) begin
            if (state_q == ST_CAP_DR) begin
                id_q  <= ID_WORD; // R4
                byp_q <= 1'b0;
                if (sel_bsr) begin
                    bsr_q <= {preload_q[BSR_LEN-1], pin_s2_q}; // R7
                end
            end else if (state_q == ST_SHIFT_DR) begin
                id_q  <= {tdi_s_q[1], id_q[ID_WIDTH-1:1]}; // R4 R21
                byp_q <= tdi_s_q[1]; // R11
                if (sel_bsr) begin
                    bsr_q <= {tdi_s_q[1], bsr_q[BSR_LEN-1:1]}; // R8 R10
                end
            end
        end
    end

    // preload stage, enable cell at msb
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preload_q <= {OE_CELL_RESET, {(BSR_LEN-1){1'b0}}}; // R15
        end else if (rise && state_q == ST_RESET) begin
            preload_q[BSR_LEN-1] <= OE_CELL_RESET; // R15
        end else if (rise && state_q == ST_UPD_DR && sel_bsr) begin
            preload_q <= bsr_q; // R9 R14
        end
    end

    // serial out source; reserved codes fall through to bypass
    always_comb begin
        tdo_d = byp_q; // R11 R17
        if (state_q == ST_SHIFT_IR) begin
            tdo_d = ir_shift_q[0];
        end else if (sel_chain) begin
            tdo_d = sel_bsr ? bsr_q[0] : id_q[0]; // R4 R8
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q      <= 1'b0;
            tdo_oe_n_q <= 1'b1;
        end else if (fall) begin
            tdo_oe_n_q <= !(state_q == ST_SHIFT_DR
                            || state_q == ST_SHIFT_IR);
            tdo_q <= tdo_d; // R21
        end
    end
    assign port.tdo_o    = tdo_q;
    assign port.tdo_oe_n = tdo_oe_n_q;

    assign pin_drive    = preload_q[BSR_LEN-2:0]; // R3
    assign pin_drive_en = (ir_q == INS_EXT_TEST); // R3
    assign mem_out_en   = (ir_q == INS_SAMPLE_HIZ) ? 1'b0 : // R6
                          (ir_q == INS_EXT_TEST) ? preload_q[BSR_LEN-1]
                                                 : 1'b1; // R12 R13
    assign instr_active = ir_q;
endmodule

/* File: scan_controller.sv */
`timescale 1ns/1ps
module scan_controller
    import scan_pkg::*;
#(
    parameter int HALF_CYCLES = TCK_HALF_CYCLES
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    scan_if.controller         port,
    input  wire logic          start,
    input  wire logic          tms_in,
    input  wire logic          tdi_in,
    output logic               busy,
    output logic               tdo_bit,
    output logic               tdo_valid
);
    import scan_pkg::*;

    logic [15:0] div_q;
    logic        tck_q, tms_q, tdi_q, busy_q, tdo_bit_q, valid_q;
    logic [1:0]  tdo_s_q;
    logic        tdo_pending_q;

    // one tck period per request; tms/tdi set while tck low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= 16'h0;
            tck_q  <= 1'b0;
            tms_q  <= 1'b1; // R19
            tdi_q  <= 1'b1;
            busy_q <= 1'b0;
        end else if (!busy_q) begin
            if (start) begin
                tms_q  <= tms_in; // R2 R14 R10
                tdi_q  <= tdi_in;
                busy_q <= 1'b1;
                div_q  <= 16'h0;
            end
        end else if (div_q == 16'(HALF_CYCLES - 1)) begin
            div_q <= 16'h0;
            tck_q <= ~tck_q;
            if (tck_q) begin
                busy_q <= 1'b0;
            end
        end else begin
            div_q <= div_q + 16'h1;
        end
    end

    // sample tdo near the next rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_s_q       <= 2'h0;
            tdo_bit_q     <= 1'b0;
            valid_q       <= 1'b0;
            tdo_pending_q <= 1'b0;
        end else begin
            tdo_s_q <= {tdo_s_q[0], port.tdo_o};
            valid_q <= 1'b0;
            if (start && !busy_q) begin
                tdo_pending_q <= 1'b1;
            end else if (tdo_pending_q && busy_q && !tck_q
                         && div_q == 16'(HALF_CYCLES - 1)) begin
                tdo_bit_q     <= tdo_s_q[1];
                valid_q       <= 1'b1;
                tdo_pending_q <= 1'b0;
            end
        end
    end

    assign port.tck  = tck_q;
    assign port.tms  = tms_q;
    assign port.tdi  = tdi_q;
    assign busy      = busy_q;
    assign tdo_bit   = tdo_bit_q;
    assign tdo_valid = valid_q;
endmodule

/* File: scan_link_sva.sv */
`timescale 1ns/1ps
module scan_link_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo_o,
    input wire logic tdo_oe_n
);
    import scan_pkg::*;
    tap_state_type st_q;
    logic          tck_q;
    logic          sh_q;
    logic [2:0]    hi_q;
    wire           rise = tck & ~tck_q;
    wire           fall = ~tck & tck_q;
    // shadow of the state machine, stepped on sampled tck edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_q <= 1'b0;
            st_q  <= ST_RESET;
            sh_q  <= 1'b0;
            hi_q  <= 3'h0;
        end else begin
            tck_q <= tck;
            if (rise) begin
                st_q <= tap_next(st_q, tms);
                hi_q <= !tms ? 3'h0 : (hi_q == 3'h5) ? hi_q : hi_q + 3'h1;
            end
            if (fall)
                sh_q <= (st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_tdo_on_low: assert property ($changed(tdo_o) |-> !tck)
        else $error("tdo changed while tck high");
    chk_oe_on_low: assert property ($changed(tdo_oe_n) |-> !tck)
        else $error("tdo enable changed while tck high");
    chk_tms_hold: assert property (tck |-> $stable(tms))
        else $error("tms moved while tck high");
    chk_tdi_hold: assert property (tck |-> $stable(tdi))
        else $error("tdi moved while tck high");
    chk_tck_width: assert property (rise |-> tck [*4] ##1 !tck)
        else $error("tck high phase not four cycles");
    chk_oe_shift: assert property (fall |-> ##4 (tdo_oe_n == !sh_q))
        else $error("tdo enable does not follow shift state");
    chk_ir_first: assert property (
        rise && st_q == ST_CAP_IR && !tms |-> ##8 tdo_o)
        else $error("first instruction bit out is not one");
    chk_reset_hiz: assert property (hi_q == 3'h5 |-> tdo_oe_n)
        else $error("tdo driven after state machine reset");
    cover property (rise && st_q == ST_UPD_IR);
    cover property (rise && st_q == ST_UPD_DR);
    cover property (hi_q == 3'h5);
endmodule

/* File: sram_scan_instruction_unit_bench.sv */
`timescale 1ns/1ps
module sram_scan_instruction_unit_bench;
    import scan_pkg::*;
    localparam int L = BSR_LEN_SMALL;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         start = 1'b0;
    logic         tms_in = 1'b1;
    logic         tdi_in = 1'b1;
    logic         busy, tdo_bit, tdo_valid, pin_drive_en, mem_out_en;
    logic [L-2:0] pin_sample = '0;
    logic [L-2:0] pin_drive;
    logic [2:0]   instr_active;
    int           n_fail = 0;
    int           n_checks = 0;
    int           cyc = 0;
    scan_if link ();
    scan_controller #(.HALF_CYCLES(4)) scan_controller_inst (.clk(clk),
        .rst_n(rst_n), .port(link), .start(start), .tms_in(tms_in),
        .tdi_in(tdi_in), .busy(busy), .tdo_bit(tdo_bit),
        .tdo_valid(tdo_valid));
    scan_device #(.BSR_LEN(L)) scan_device_inst (.clk(clk), .rst_n(rst_n),
        .port(link), .pin_sample(pin_sample), .pin_drive(pin_drive),
        .pin_drive_en(pin_drive_en), .mem_out_en(mem_out_en),
        .instr_active(instr_active));
    scan_link_checker scan_link_checker_inst (.clk(clk), .rst_n(rst_n),
        .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo_o(link.tdo_o),
        .tdo_oe_n(link.tdo_oe_n));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [95:0] exp, logic [95:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one tck cycle; q is the tdo bit seen before its rising edge
    task automatic step(input logic m, input logic d, output logic q);
        q = 1'b0;
        @(posedge clk);
        #2;
        start = 1'b1;
        tms_in = m;
        tdi_in = d;
        @(posedge clk);
        #2;
        start = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (tdo_valid === 1'b1)
                q = tdo_bit;
            if (busy === 1'b0)
                break;
        end
    endtask
    task automatic reset_tap();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    // idle to idle through one register, lsb first
    task automatic scan(input logic ir, input int n, input logic [95:0] si,
                        output logic [95:0] so);
        logic q;
        so = '0;
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, si[i], q);
            so[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    function automatic logic [95:0] expect_dr(logic [2:0] c, logic [95:0] d,
                                              logic [L-2:0] p);
        if (c == INS_IDENT)
            return {64'h0, ID_WORD_DEFAULT};
        if (c inside {INS_EXT_TEST, INS_SAMPLE_HIZ, INS_SAMPLE_PRE})
            return {64'h0, p[31:0]};
        return {64'h0, d[30:0], 1'b0};
    endfunction
    initial begin
        logic [95:0] d, so;
        logic [2:0]  c;
        void'($urandom(12));
        repeat (3) @(posedge clk);
        #2;
        rst_n = 1'b1;
        chk("instr", INS_IDENT, instr_active);
        chk("out en", 96'h1, mem_out_en);
        chk("tdo oe_n", 96'h1, link.tdo_oe_n);
        reset_tap();
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            pin_sample = (L-1)'({$urandom(), $urandom(), $urandom()});
            d = {$urandom(), $urandom(), $urandom()};
            scan(1'b1, 3, {93'h0, c}, so);
            chk("ir capture", 96'h1, so[1:0]);
            if (c inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7})
                chk("instr", c, instr_active);
            chk("out en", c != INS_SAMPLE_HIZ, mem_out_en);
            chk("drive en", c == INS_EXT_TEST, pin_drive_en);
            scan(1'b0, 32, d, so);
            chk("dr out", expect_dr(c, d, pin_sample), so);
        end
        pin_sample = (L-1)'({$urandom(), $urandom(), $urandom()});
        d = {$urandom(), $urandom(), $urandom()};
        d[L-1] = 1'b0;
        scan(1'b1, 3, {93'h0, INS_SAMPLE_PRE}, so);
        scan(1'b0, L, d, so);
        chk("capture", pin_sample, so[L-2:0]);
        chk("preload", d[L-2:0], pin_drive);
        chk("out en", 96'h1, mem_out_en);
        scan(1'b1, 3, {93'h0, INS_EXT_TEST}, so);
        chk("out en", 96'h0, mem_out_en);
        d[L-1] = 1'b1;
        scan(1'b0, L, d, so);
        chk("out en", 96'h1, mem_out_en);
        d[L-1] = 1'b0;
        scan(1'b0, L, d, so);
        chk("out en", 96'h0, mem_out_en);
        reset_tap();
        chk("instr", INS_IDENT, instr_active);
        scan(1'b1, 3, {93'h0, INS_EXT_TEST}, so);
        chk("out en", 96'h1, mem_out_en);
        wrap_up();
    end
endmodule
